// ---- dv/ucrl_channel_asserts.sv ----
// Port checker of the UART channel register map and loopback
`timescale 1ns/100ps
`default_nettype none
module ucrl_channel_asserts
  import ucrl_pkg::*;
(
  // Clock, reset and enable
  input wire logic        clk_in,
  input wire logic        resetn_in,
  input wire logic        ce_in,
  // Register port
  input wire ucrl_bus_t   bus_in,
  input wire logic [7:0]  rdata_out,
  // Serial and modem pins
  input wire logic        serial_in,
  input wire ucrl_modem_t modem_in,
  input wire logic        serial_out,
  input wire logic        rts_n_out,
  input wire logic        dtr_n_out
);
  logic [7:0] lcr_ff, mcr_ff, ien_ff, wd, dvr;
  logic [7:0] dv_ff [3];
  logic [3:0] wa;
  logic [1:0] age_ff;
  logic       enh_ff, qen_ff, we;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // Bus aliases
  assign we  = bus_in.wr && ce_in;
  assign wa  = bus_in.addr;
  assign wd  = bus_in.wdata;
  assign dvr = dv_ff[wa[1:0]];
  // Shadow of writable fields, gated like the device
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      lcr_ff <= 8'h00;
      mcr_ff <= 8'h00;
      ien_ff <= 8'h00;
      dv_ff  <= '{default: 8'h00};
      enh_ff <= 1'b0;
      qen_ff <= 1'b0;
    end
    else if (we)
    begin
      if (wa == 4'h3)
        lcr_ff <= wd;
      if (wa == 4'h4)
        mcr_ff <= {enh_ff ? wd[7:5] : mcr_ff[7:5], wd[4:0]};
      if (wa == 4'h9)
        enh_ff <= wd[4];
      if (lcr_ff[7] && wa < 4'h3)
        dv_ff[wa[1:0]] <= wd;
      if (!lcr_ff[7] && wa == 4'h1)
        ien_ff <= {enh_ff ? wd[7:5] : ien_ff[7:5], 1'b0, wd[3:0]};
      if (!lcr_ff[7] && wa == 4'h2)
        qen_ff <= wd[0];
    end
  end
  // Cycles since the last modem control write, saturating
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      age_ff <= 2'h0;
    else if (we && wa == 4'h4)
      age_ff <= 2'h0;
    else if (age_ff != 2'h3)
      age_ff <= age_ff + 2'h1;
  end
  sequence s_rd(logic [3:0] a);
    bus_in.rd && ce_in && wa == a;
  endsequence
  sequence s_loop;
    age_ff == 2'h3 && mcr_ff[4];
  endsequence
  mcr_read_a: assert property (s_rd(4'h4) |=> rdata_out == $past(mcr_ff))
    else $error("bad modem control read");
  ien_read_a: assert property (s_rd(4'h1) ##0 !lcr_ff[7] |=> rdata_out == $past(ien_ff))
    else $error("bad irq enable read");
  div_read_a: assert property (bus_in.rd && ce_in && lcr_ff[7] && wa < 4'h3 |=> rdata_out == $past(dvr))
    else $error("bad divisor read");
  isr_top_a: assert property (s_rd(4'h2) ##0 !lcr_ff[7] |=> rdata_out[7:5] == {{2{$past(qen_ff)}}, 1'b0})
    else $error("bad irq status top bits");
  flag_top_a: assert property (s_rd(4'hc) |=> rdata_out[7:4] == 4'h0)
    else $error("flow flag top bits set");
  loop_status_a: assert property (s_rd(4'h6) ##0 s_loop |=> rdata_out[7:4] == $past({mcr_ff[3:2], mcr_ff[0], mcr_ff[1]}))
    else $error("bad loopback modem status");
  loop_pins_a: assert property (s_loop |-> serial_out && rts_n_out && dtr_n_out)
    else $error("pins active in loopback");
  flow_pins_a: assert property (age_ff == 2'h3 && !mcr_ff[4] |-> rts_n_out == !mcr_ff[1] && dtr_n_out == !mcr_ff[0])
    else $error("control pins do not follow");
endmodule // ucrl_channel_asserts
bind ucrl_channel ucrl_channel_asserts ucrl_channel_asserts_i (
  .clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in), .bus_in(bus_in),
  .rdata_out(rdata_out), .serial_in(serial_in), .modem_in(modem_in),
  .serial_out(serial_out), .rts_n_out(rts_n_out), .dtr_n_out(dtr_n_out)
);
`default_nettype wire

// ---- dv/ucrl_channel_regmap_loopback_bench.sv ----
// Self-checking bench of the UART channel register map and loopback
`timescale 1ns/100ps
`default_nettype none
module ucrl_channel_regmap_loopback_bench
  import ucrl_pkg::*;
;
  logic        clk_in, resetn_in, ce_in, serial_in;
  logic        ser_o, rts_n, dtr_n;
  logic [7:0]  rdata, v, d;
  logic [3:0]  mp;
  ucrl_bus_t   bus;
  ucrl_modem_t modem;
  int          n_errors, samples_checked, k, ien;
  int          mdl [16];
  int          dvm [3];
  int          sent_q [$];
  logic [3:0]  rw [6] = '{4'h1, 4'h3, 4'h4, 4'h7, 4'h8, 4'h9};
  // Free-running clock
  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  ucrl_channel ucrl_channel_i (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
    .bus_in(bus), .rdata_out(rdata), .serial_in(serial_in), .modem_in(modem),
    .serial_out(ser_o), .rts_n_out(rts_n), .dtr_n_out(dtr_n));
  ucrl_host ucrl_host_i (.clk_in(clk_in), .rdata_in(rdata), .bus_out(bus));
  // Verdict and end of run
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Byte comparison
  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Pin comparison
  task automatic cmp_pin(input logic got, input logic exp);
    cmp_reg({7'h00, got}, {7'h00, exp});
  endtask
  // Read one place and compare the masked byte
  task automatic chk(input logic [3:0] a, input int m, input int e);
    logic [7:0] got;
    ucrl_host_i.rd(a, got);
    cmp_reg(got & 8'(m), 8'(e & m));
  endtask
  // Poll one place until the masked byte matches; running out is a mismatch
  task automatic wait_rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] got;
    got = ~e;
    for (int n = 0; n < 300 && (got & m) !== e; n++)
      ucrl_host_i.rd(a, got);
    if ((got & m) !== e)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: wait on %h timed out", $time, a);
      tally_and_finish();
    end
  endtask
  // Host write plus the reference model update
  task automatic put(input logic [3:0] a, input logic [7:0] wd);
    ucrl_host_i.wr(a, wd);
    if (a < 4'h3 && (mdl[3] & 'h80) != 0)
      dvm[a] = wd;
    else if (a == 4'h1)
      ien = ((mdl[9] & 'h10) != 0 ? wd & 'he0 : ien & 'he0) | (wd & 'h0f);
    else if (a == 4'h4)
      mdl[4] = ((mdl[9] & 'h10) != 0 ? wd & 'he0 : mdl[4] & 'he0) | (wd & 'h1f);
    else
      mdl[a] = wd;
  endtask
  // Model value of a plain read/write place
  function automatic int mexp(input logic [3:0] a);
    return (a == 4'h1) ? ien : mdl[a];
  endfunction
  // Main sequence
  initial
  begin
    resetn_in = 1'b0;
    ce_in = 1'b1;
    serial_in = 1'b1;
    modem = '1;
    n_errors = 0;
    samples_checked = 0;
    ien = 0;
    mdl = '{default: 0};
    dvm = '{default: 0};
    void'($urandom(81));
    repeat (12) @(posedge clk_in);
    resetn_in <= 1'b1;
    foreach (rw[j]) chk(rw[j], 'hff, 0);
    chk(4'h5, 'hff, 'h60);
    $display("reset test done");
    repeat (4)
      foreach (rw[j])
      begin
        v = 8'($urandom);
        if (rw[j] == 4'h3) v[7:6] = 2'h0;
        if (rw[j] == 4'h4) v[4] = 1'b0;
        put(rw[j], v);
        chk(rw[j], 'hff, mexp(rw[j]));
      end
    put(4'h9, 8'h10);
    put(4'h1, 8'h00);
    put(4'h9, 8'h00);
    put(4'h1, 8'hff);
    chk(4'h1, 'hff, 'h0f);
    put(4'h4, 8'hef);
    chk(4'h4, 'hff, mdl[4]);
    put(4'h9, 8'h10);
    put(4'h1, 8'hff);
    chk(4'h1, 'hff, 'hef);
    put(4'h5, 8'h00);
    chk(4'h5, 'hff, 'h60);
    ce_in <= 1'b0;
    ucrl_host_i.wr(4'h7, ~8'(mdl[7]));
    ce_in <= 1'b1;
    chk(4'h7, 'hff, mdl[7]);
    $display("read write test done");
    put(4'h3, 8'h80);
    for (k = 0; k < 3; k++) put(4'(k), 8'($urandom));
    for (k = 0; k < 3; k++) chk(4'(k), 'hff, dvm[k]);
    put(4'h0, 8'h01);
    put(4'h1, 8'h00);
    put(4'h3, 8'h03);
    chk(4'h1, 'hff, ien);
    chk(4'h2, 'he0, 'h00);
    put(4'h2, 8'h01);
    chk(4'h2, 'he0, 'hc0);
    $display("page test done");
    for (k = 12; k < 16; k++) put(4'(k), 8'(k == 12 ? 'h13 : k + 'h10));
    mp = 4'($urandom);
    v = 8'($urandom);
    modem <= mp;
    serial_in <= 1'b0;
    v[1] = ~v[0];
    put(4'h3, 8'h43);
    put(4'h4, {4'h1, v[3:0]});
    repeat (4) @(posedge clk_in);
    cmp_pin(ser_o, 1'b1);
    cmp_pin(rts_n, 1'b1);
    cmp_pin(dtr_n, 1'b1);
    chk(4'h6, 'hf0, {v[3], v[2], v[0], v[1], 4'h0});
    modem <= ~mp;
    chk(4'h6, 'hf0, {v[3], v[2], v[0], v[1], 4'h0});
    sent_q = '{'h13, 'h80 | $urandom, 'h80 | $urandom};
    foreach (sent_q[j])
    begin
      put(4'h0, 8'(sent_q[j]));
      wait_rd(4'h5, 8'h01, 8'h01);
      chk(4'h2, 'hff, j == 0 ? 'hd4 : 'hc4);
      chk(4'hb, 'hff, 1);
      chk(4'h0, 'hff, sent_q[j]);
      chk(4'h2, 'h0f, 'h02);
      chk(4'hb, 'hff, 0);
      if (j == 0) chk(4'hc, 'hff, 'h05);
    end
    chk(4'hc, 'hff, 'h00);
    chk(4'ha, 'hff, 0);
    v = 8'($urandom) | 8'h80;
    d = 8'($urandom) | 8'h80;
    put(4'h0, v);
    put(4'h0, d);
    wait_rd(4'h2, 8'h0f, 8'h06);
    chk(4'h5, 'hbf, 'h23);
    chk(4'h0, 'hff, d);
    chk(4'h5, 'h03, 'h00);
    $display("loopback test done");
    serial_in <= 1'b1;
    put(4'h3, 8'h03);
    put(4'h4, 8'h03);
    mp = 4'($urandom);
    modem <= mp;
    repeat (4) @(posedge clk_in);
    cmp_pin(rts_n, 1'b0);
    cmp_pin(dtr_n, 1'b0);
    cmp_pin(ser_o, 1'b1);
    chk(4'h6, 'hf0, {~mp, 4'h0});
    $display("normal test done");
    tally_and_finish();
  end
endmodule // ucrl_channel_regmap_loopback_bench
`default_nettype wire

// ---- dv/ucrl_host.sv ----
// Host model driving the channel register port
`timescale 1ns/100ps
`default_nettype none
module ucrl_host
  import ucrl_pkg::*;
(
  // Clock
  input  wire logic       clk_in,
  // Register port
  input  wire logic [7:0] rdata_in,
  output var  ucrl_bus_t  bus_out
);
  // Strobes idle low from time zero
  initial bus_out = '0;
  // One-cycle write; address and data flip once released
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    bus_out <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_in);
    bus_out <= '{~a, ~d, 1'b0, 1'b0};
  endtask
  // One-cycle read; data taken in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_in);
    bus_out <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_in);
    bus_out <= '{~a, 8'hff, 1'b0, 1'b0};
    @(posedge clk_in);
    d = rdata_in;
  endtask
endmodule // ucrl_host
`default_nettype wire

// ---- verilog/ucrl_channel.sv ----
// One UART channel: register map, simple serial engine and internal loopback
`timescale 1ns/100ps
`default_nettype none
`include "ucrl_regs.svh"

module ucrl_channel
  import ucrl_pkg::*;
(
  // Clock, reset and enable
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire logic        ce_in,
  // Register port
  input  wire ucrl_bus_t   bus_in,
  output logic      [7:0]  rdata_out,
  // Serial and modem pins
  input  wire logic        serial_in,
  input  wire ucrl_modem_t modem_in,
  output logic             serial_out,
  output logic             rts_n_out,
  output logic             dtr_n_out
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0]  dlow_ff, dhigh_ff, dfrac_ff, ien_ff, qctl_ff, lctl_ff, mctl_ff;
  logic [7:0]  dly_ff, scr_ff, fctl_ff, efn_ff, tx_trigger_level_ff, rx_trigger_level_ff;
  logic [7:0]  p1_ff, p2_ff, r1_ff, r2_ff;
  logic [7:0]  thr_ff, rhr_ff, tsr_ff, rsr_ff;
  logic        thr_full_ff, rhr_full_ff, ovr_ff, frm_ff;
  logic [3:0]  flags_ff, mdelta_ff, mprev_ff, mstat_ff;
  logic [15:0] bcnt_ff;
  logic        tick_ff;
  ucrl_ser_t   txs_ff, rxs_ff;
  logic [3:0]  txph_ff, rxph_ff, txbit_ff, rxbit_ff;
  logic        rx_in;
  logic [3:0]  mstat_raw;
  logic        loop, dlab, enh, wr_hit, rd_hit;
  logic        rx_done, rx_ok;
  logic [3:0]  isq_code;
  logic [7:0]  nxt_rdata;

  assign loop = mctl_ff[`UCRL_MCTL_LOOP];
  assign dlab = lctl_ff[`UCRL_LCTL_DIV];
  assign enh  = efn_ff[`UCRL_EFN_ENH];

  // Write and read decode of one address
  function automatic logic hit(input logic [3:0] a, input logic [3:0] r, input logic s);
    hit = s && (a == r);
  endfunction

  // Keep guarded bits of a write unless enhanced access is on
  function automatic logic [7:0] gated(input logic [7:0] old, input logic [7:0] nw,
                                       input logic [7:0] m, input logic e);
    gated = e ? nw : ((nw & ~m) | (old & m));
  endfunction

  // ----------------------------------------
  // Control register writes
  // ----------------------------------------
  // Overlaid registers are chosen by divisor latch bit and direction
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      dlow_ff  <= `UCRL_RST_BYTE;
      dhigh_ff <= `UCRL_RST_BYTE;
      dfrac_ff <= `UCRL_RST_BYTE;
      ien_ff   <= `UCRL_RST_BYTE;
      qctl_ff  <= `UCRL_RST_BYTE;
      lctl_ff  <= `UCRL_RST_BYTE;
      mctl_ff  <= `UCRL_RST_BYTE;
      dly_ff   <= `UCRL_RST_BYTE;
      scr_ff   <= `UCRL_RST_BYTE;
      fctl_ff  <= `UCRL_RST_BYTE;
      efn_ff   <= `UCRL_RST_BYTE;
      tx_trigger_level_ff <= `UCRL_RST_BYTE;
      rx_trigger_level_ff <= `UCRL_RST_BYTE;
      p1_ff    <= `UCRL_RST_BYTE;
      p2_ff    <= `UCRL_RST_BYTE;
      r1_ff    <= `UCRL_RST_BYTE;
      r2_ff    <= `UCRL_RST_BYTE;
    end
    else if (ce_in && bus_in.wr)
    begin
      unique case (bus_in.addr)
        `UCRL_A_DATA:
          if (dlab) dlow_ff <= bus_in.wdata;
        `UCRL_A_IEN:
          if (dlab) dhigh_ff <= bus_in.wdata;
          else ien_ff <= gated(ien_ff, bus_in.wdata & 8'hef,
                               `UCRL_IEN_ENH_MASK, enh);
        `UCRL_A_ISQ:
          if (dlab) dfrac_ff <= bus_in.wdata;
          else qctl_ff <= gated(qctl_ff, bus_in.wdata & 8'hf9,
                                `UCRL_QCTL_ENH_MASK, enh);
        `UCRL_A_LCTL:    lctl_ff <= bus_in.wdata;
        `UCRL_A_MCTL:
          mctl_ff <= gated(mctl_ff, bus_in.wdata, `UCRL_MCTL_ENH_MASK, enh);
        `UCRL_A_LSTS:    ;
        `UCRL_A_MSTS:
          if (enh) dly_ff <= bus_in.wdata;
        `UCRL_A_SCR:     scr_ff <= bus_in.wdata;
        `UCRL_A_FCTL:    fctl_ff <= bus_in.wdata;
        `UCRL_A_EFN:     efn_ff <= bus_in.wdata;
        `UCRL_A_TX_FILL_COUNT:   tx_trigger_level_ff <= bus_in.wdata;
        `UCRL_A_RX_FILL_COUNT:   rx_trigger_level_ff <= bus_in.wdata;
        `UCRL_A_PAUSE1:  p1_ff <= bus_in.wdata;
        `UCRL_A_PAUSE2:  p2_ff <= bus_in.wdata;
        `UCRL_A_RESUME1: r1_ff <= bus_in.wdata;
        `UCRL_A_RESUME2: r2_ff <= bus_in.wdata;
      endcase
    end
  end

  // ----------------------------------------
  // Baud generator
  // ----------------------------------------
  // One oversample tick each divisor count of clocks, also in loopback
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      bcnt_ff <= 16'h0000;
      tick_ff <= 1'b0;
    end
    else if (ce_in)
    begin
      tick_ff <= 1'b0;
      if ({dhigh_ff, dlow_ff} != 16'h0000)
      begin
        if (bcnt_ff + 16'h0001 >= {dhigh_ff, dlow_ff})
        begin
          bcnt_ff <= 16'h0000;
          tick_ff <= 1'b1;
        end
        else
          bcnt_ff <= bcnt_ff + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  assign wr_hit = hit(bus_in.addr, `UCRL_A_DATA, bus_in.wr) && !dlab;
  assign rd_hit = hit(bus_in.addr, `UCRL_A_DATA, bus_in.rd) && !dlab;

  // Holding byte loads the shifter, frame is start, eight data, stop
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      thr_ff      <= `UCRL_RST_BYTE;
      thr_full_ff <= 1'b0;
      tsr_ff      <= `UCRL_RST_FILL;
      txs_ff      <= UCRL_IDLE;
      txph_ff     <= 4'h0;
      txbit_ff    <= 4'h0;
    end
    else if (ce_in)
    begin
      if (wr_hit)
      begin
        thr_ff      <= bus_in.wdata;
        thr_full_ff <= 1'b1;
      end
      if (txs_ff == UCRL_IDLE && thr_full_ff && !wr_hit)
      begin
        tsr_ff      <= thr_ff;
        thr_full_ff <= 1'b0;
        txs_ff      <= UCRL_START;
        txph_ff     <= 4'h0;
      end
      else if (tick_ff && txs_ff != UCRL_IDLE)
      begin
        txph_ff <= txph_ff + 4'h1;
        if (txph_ff == `UCRL_OVS)
        begin
          unique case (txs_ff)
            UCRL_START:
            begin
              txs_ff   <= UCRL_DATA;
              txbit_ff <= 4'h0;
            end
            UCRL_DATA:
            begin
              txbit_ff <= txbit_ff + 4'h1;
              if (txbit_ff == 4'h7) txs_ff <= UCRL_STOP;
            end
            UCRL_STOP:  txs_ff <= UCRL_IDLE;
            UCRL_IDLE:  txs_ff <= UCRL_IDLE;
          endcase
        end
      end
    end
  end

  // Serial level that the shifter puts out
  logic tx_bit;
  assign tx_bit = (txs_ff == UCRL_START) ? 1'b0 :
                  (txs_ff == UCRL_DATA)  ? tsr_ff[txbit_ff[2:0]] : 1'b1;

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  assign rx_in   = loop ? tx_bit : serial_in;
  assign rx_done = tick_ff && rxs_ff == UCRL_STOP && rxph_ff == `UCRL_OVS_MID;
  assign rx_ok   = rx_in;

  // Start bit checked at mid bit, data sampled at mid bit
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rsr_ff      <= `UCRL_RST_BYTE;
      rhr_ff      <= `UCRL_RST_BYTE;
      rhr_full_ff <= 1'b0;
      ovr_ff      <= 1'b0;
      frm_ff      <= 1'b0;
      rxs_ff      <= UCRL_IDLE;
      rxph_ff     <= 4'h0;
      rxbit_ff    <= 4'h0;
    end
    else if (ce_in)
    begin
      if (rd_hit) rhr_full_ff <= 1'b0;
      if (hit(bus_in.addr, `UCRL_A_LSTS, bus_in.rd))
      begin
        ovr_ff <= 1'b0;
        frm_ff <= 1'b0;
      end
      if (tick_ff)
      begin
        rxph_ff <= rxph_ff + 4'h1;
        unique case (rxs_ff)
          UCRL_IDLE:
            if (!rx_in)
            begin
              rxs_ff  <= UCRL_START;
              rxph_ff <= 4'h0;
            end
          UCRL_START:
            if (rxph_ff == `UCRL_OVS_MID)
            begin
              rxs_ff   <= rx_in ? UCRL_IDLE : UCRL_DATA;
              rxph_ff  <= `UCRL_OVS_MID + 4'h1;
              rxbit_ff <= 4'h0;
            end
          UCRL_DATA:
            if (rxph_ff == `UCRL_OVS_MID)
            begin
              rsr_ff   <= {rx_in, rsr_ff[7:1]};
              rxbit_ff <= rxbit_ff + 4'h1;
              if (rxbit_ff == 4'h7) rxs_ff <= UCRL_STOP;
            end
          UCRL_STOP:
            if (rx_done)
            begin
              rxs_ff      <= UCRL_IDLE;
              rhr_ff      <= rsr_ff;
              rhr_full_ff <= 1'b1;
              // Error events win over a clearing read in the same cycle
              if (rhr_full_ff && !rd_hit) ovr_ff <= 1'b1;
              if (!rx_ok) frm_ff <= 1'b1;
            end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Flow character flags
  // ----------------------------------------
  // Set on matching characters; read clears, a new match wins
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      flags_ff <= 4'h0;
    else if (ce_in)
    begin
      if (hit(bus_in.addr, `UCRL_A_PAUSE1, bus_in.rd))
        flags_ff <= 4'h0;
      if (rx_done && (rsr_ff == p1_ff || rsr_ff == p2_ff)) flags_ff[0] <= 1'b1;
      if (rx_done && (rsr_ff == r1_ff || rsr_ff == r2_ff)) flags_ff[1] <= 1'b1;
      if (wr_hit && (bus_in.wdata == p1_ff || bus_in.wdata == p2_ff)) flags_ff[2] <= 1'b1;
      if (wr_hit && (bus_in.wdata == r1_ff || bus_in.wdata == r2_ff)) flags_ff[3] <= 1'b1;
    end
  end

  // ----------------------------------------
  // Modem status
  // ----------------------------------------
  // Loopback feeds status from control bits, pins are not looked at
  assign mstat_raw = loop ? {mctl_ff[`UCRL_MCTL_OP2], mctl_ff[`UCRL_MCTL_OP1],
                             mctl_ff[`UCRL_MCTL_DTR], mctl_ff[`UCRL_MCTL_RTS]}
                          : ~{modem_in.cd_n, modem_in.ri_n,
                              modem_in.dsr_n, modem_in.cts_n};

  // Delta flags set on change and clear on status read, change wins
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      mstat_ff  <= 4'h0;
      mprev_ff  <= 4'h0;
      mdelta_ff <= 4'h0;
    end
    else if (ce_in)
    begin
      mstat_ff <= mstat_raw;
      mprev_ff <= mstat_ff;
      mdelta_ff <= (hit(bus_in.addr, `UCRL_A_MSTS, bus_in.rd) ? 4'h0 : mdelta_ff)
                   | (mstat_ff ^ mprev_ff);
    end
  end

  // ----------------------------------------
  // Interrupt source and read mux
  // ----------------------------------------
  // Highest priority enabled source
  always_comb
  begin
    if (ien_ff[2] && (ovr_ff || frm_ff))      isq_code = `UCRL_ISQ_LINE;
    else if (ien_ff[0] && rhr_full_ff)        isq_code = `UCRL_ISQ_RXD;
    else if (ien_ff[1] && !thr_full_ff)       isq_code = `UCRL_ISQ_TXE;
    else if (ien_ff[3] && mdelta_ff != 4'h0)  isq_code = `UCRL_ISQ_MDM;
    else                                      isq_code = `UCRL_ISQ_NONE;
  end

  // Read data by address, latch bit and direction
  always_comb
  begin
    nxt_rdata = 8'h00;
    unique case (bus_in.addr)
      `UCRL_A_DATA:    nxt_rdata = dlab ? dlow_ff : rhr_ff;
      `UCRL_A_IEN:     nxt_rdata = dlab ? dhigh_ff : ien_ff;
      `UCRL_A_ISQ:     nxt_rdata = dlab ? dfrac_ff :
                         {{2{qctl_ff[`UCRL_QCTL_EN]}}, 1'b0,
                          enh && flags_ff != 4'h0, isq_code};
      `UCRL_A_LCTL:    nxt_rdata = lctl_ff;
      `UCRL_A_MCTL:    nxt_rdata = mctl_ff;
      `UCRL_A_LSTS:    nxt_rdata = {frm_ff, txs_ff == UCRL_IDLE && !thr_full_ff,
                                    !thr_full_ff, 1'b0, frm_ff, 1'b0,
                                    ovr_ff, rhr_full_ff};
      `UCRL_A_MSTS:    nxt_rdata = {mstat_ff, mdelta_ff};
      `UCRL_A_SCR:     nxt_rdata = scr_ff;
      `UCRL_A_FCTL:    nxt_rdata = fctl_ff;
      `UCRL_A_EFN:     nxt_rdata = efn_ff;
      `UCRL_A_TX_FILL_COUNT:   nxt_rdata = {7'h00, thr_full_ff};
      `UCRL_A_RX_FILL_COUNT:   nxt_rdata = {7'h00, rhr_full_ff};
      `UCRL_A_PAUSE1:  nxt_rdata = {4'h0, flags_ff};
      `UCRL_A_PAUSE2:  nxt_rdata = 8'h00;
      `UCRL_A_RESUME1: nxt_rdata = 8'h00;
      `UCRL_A_RESUME2: nxt_rdata = 8'h00;
    endcase
  end

  // ----------------------------------------
  // Output flops
  // ----------------------------------------
  // Read data for one cycle, pins parked in loopback
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rdata_out  <= 8'h00;
      serial_out <= 1'b1;
      rts_n_out  <= 1'b1;
      dtr_n_out  <= 1'b1;
    end
    else if (ce_in)
    begin
      rdata_out  <= bus_in.rd ? nxt_rdata : 8'h00;
      serial_out <= loop ? 1'b1 : (tx_bit & ~lctl_ff[`UCRL_LCTL_BRK]);
      rts_n_out  <= loop ? 1'b1 : ~mctl_ff[`UCRL_MCTL_RTS];
      dtr_n_out  <= loop ? 1'b1 : ~mctl_ff[`UCRL_MCTL_DTR];
    end
  end
endmodule // ucrl_channel
`default_nettype wire

// ---- verilog/ucrl_pkg.sv ----
// Types shared by the UART channel register block
`default_nettype none
package ucrl_pkg;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ucrl_bus_t;
  typedef struct packed {
    logic cd_n;
    logic ri_n;
    logic dsr_n;
    logic cts_n;
  } ucrl_modem_t;
  typedef enum logic [1:0] {
    UCRL_IDLE  = 2'b00,
    UCRL_START = 2'b01,
    UCRL_DATA  = 2'b10,
    UCRL_STOP  = 2'b11
  } ucrl_ser_t;
endpackage
`default_nettype wire

// ---- verilog/ucrl_regs.svh ----
// Register offsets, field positions and reset values of the UART channel
`ifndef UCRL_REGS_SVH
`define UCRL_REGS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define UCRL_A_DATA    4'h0
`define UCRL_A_IEN     4'h1
`define UCRL_A_ISQ     4'h2
`define UCRL_A_LCTL    4'h3
`define UCRL_A_MCTL    4'h4
`define UCRL_A_LSTS    4'h5
`define UCRL_A_MSTS    4'h6
`define UCRL_A_SCR     4'h7
`define UCRL_A_FCTL    4'h8
`define UCRL_A_EFN     4'h9
`define UCRL_A_TX_FILL_COUNT   4'ha
`define UCRL_A_RX_FILL_COUNT   4'hb
`define UCRL_A_PAUSE1  4'hc
`define UCRL_A_PAUSE2  4'hd
`define UCRL_A_RESUME1 4'he
`define UCRL_A_RESUME2 4'hf
// ----------------------------------------
// Field positions
// ----------------------------------------
`define UCRL_LCTL_DIV   7
`define UCRL_LCTL_BRK   6
`define UCRL_MCTL_LOOP  4
`define UCRL_MCTL_OP2   3
`define UCRL_MCTL_OP1   2
`define UCRL_MCTL_RTS   1
`define UCRL_MCTL_DTR   0
`define UCRL_EFN_ENH    4
`define UCRL_QCTL_EN    0
// Bits guarded by the enhanced enable
`define UCRL_IEN_ENH_MASK  8'he0
`define UCRL_QCTL_ENH_MASK 8'h30
`define UCRL_MCTL_ENH_MASK 8'he0
// ----------------------------------------
// Reset values and interrupt codes
// ----------------------------------------
`define UCRL_RST_BYTE   8'h00
`define UCRL_RST_FILL   8'hff
`define UCRL_ISQ_NONE   4'h1
`define UCRL_ISQ_LINE   4'h6
`define UCRL_ISQ_RXD    4'h4
`define UCRL_ISQ_TXE    4'h2
`define UCRL_ISQ_MDM    4'h0
`define UCRL_OVS        4'hf
`define UCRL_OVS_MID    4'h7
`define UCRL_FRAME_BITS 4'h9
`endif
